// >>> sim/sar_adc_sequencer_test.sv
// Self-checking bench for the converter sequencer.
// Assumes the front-end model and the bound checker are compiled.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_test;
  logic MCLK_I = 1'b0;
  logic RST_B_I = 1'b0;
  logic [7:0] ADDR_I = 8'h00;
  logic [7:0] WDATA_I = 8'h00;
  logic WR_I = 1'b0;
  logic RD_I = 1'b0;
  logic SLEEP_I = 1'b0;
  logic CMP_I;
  logic [7:0] RDATA_O;
  logic [4:0] CH_SEL_O;
  logic REF_INT_O;
  logic REF_LVL_O;
  logic SAMPLE_O;
  logic [11:0] TRIAL_O;
  logic BUSY_O;
  logic IRQ_O;
  logic [11:0] level = 12'h000;
  logic [15:0] rv;
  logic [15:0] ev;
  logic [7:0] fmt;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  int k;
  int div [4] = '{8, 16, 32, 128};
  logic [4:0] channel_select [4] = '{5'h11, 5'h12, 5'h00, 5'h05};

  sas_adc_seq uut (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .SLEEP_I(SLEEP_I), .CMP_I(CMP_I), .CH_SEL_O(CH_SEL_O),
    .REF_INT_O(REF_INT_O), .REF_LVL_O(REF_LVL_O), .SAMPLE_O(SAMPLE_O),
    .TRIAL_O(TRIAL_O), .BUSY_O(BUSY_O), .IRQ_O(IRQ_O));
  sas_afe_model afe (.clk_i(MCLK_I), .sample_i(SAMPLE_O),
    .trial_i(TRIAL_O), .level_i(level), .cmp_o(CMP_I));

  // Clock and a cycle ceiling well above the 30k cycles expected
  always #4 MCLK_I = ~MCLK_I;
  always @(posedge MCLK_I)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One-cycle strobes launched just after a rising edge
  task automatic wr(input logic [7:0] a, d);
    @(posedge MCLK_I);
    ADDR_I <= a;
    WDATA_I <= d;
    WR_I <= 1'b1;
    @(posedge MCLK_I);
    WR_I <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge MCLK_I);
    ADDR_I <= a;
    RD_I <= 1'b1;
    @(posedge MCLK_I);
    RD_I <= 1'b0;
    @(negedge MCLK_I);
    rv = {8'h00, RDATA_O};
  endtask : rd

  // Bounded wait, so a stuck status bit shows as a wrong duration
  task automatic wait_done();
    n = 0;
    do
    begin
      @(negedge MCLK_I);
      n++;
    end
    while (BUSY_O === 1'b1 && n < 3000);
  endtask : wait_done

  function automatic logic [15:0] res_exp(input logic [11:0] v, logic al);
    return al ? {6'h00, v[11:10], v[9:2]} : {v[11:4], v[3:0], 4'h0};
  endfunction : res_exp

  task automatic chk_res(input logic al);
    ev = res_exp(level, al);
    rd(8'h9e);
    chk("result_high", rv, {8'h00, ev[15:8]});
    rd(8'h9f);
    chk("result_low", rv, {8'h00, ev[7:0]});
  endtask : chk_res

  initial
  begin
    void'($urandom(32'h8f0597d9));
    repeat (20) @(posedge MCLK_I);
    RST_B_I <= 1'b1;
    rd(8'h9d);
    chk("main_reset", rv, 16'h0000);
    wr(8'h9c, 8'hff);
    rd(8'h9c);
    chk("fmt_unused", rv, 16'h00c5);
    chk("ref_pins", {14'h0, REF_INT_O, REF_LVL_O}, 16'h0003);
    wr(8'h9e, 8'h5a);
    rd(8'h9e);
    chk("result_ro", rv, 16'h0000);
    wr(8'h9c, 8'h00);
    wr(8'h9d, 8'h03);
    repeat (4) @(negedge MCLK_I);
    chk("go_with_enable", {15'h0, BUSY_O}, 16'h0000);
    $display("test registers done");
    // Every clock code, slow ones on the internal reference
    for (k = 3; k >= 0; k--)
    begin
      level = 12'($urandom);
      fmt = {1'b0, channel_select[k][4], 3'h0, k > 1, 1'b0, 1'($urandom)};
      wr(8'h9c, fmt);
      if (k == 3)
        repeat (25000) @(posedge MCLK_I);
      wr(8'h9d, {2'(k), channel_select[k][3:0], 2'b01});
      repeat (50) @(posedge MCLK_I);
      chk("channel", {11'h0, CH_SEL_O}, {11'h0, channel_select[k]});
      wr(8'h9d, {2'(k), channel_select[k][3:0], 2'b11});
      @(negedge MCLK_I);
      chk("trial_start", {4'h0, TRIAL_O}, 16'h0800);
      wait_done();
      chk("conv_time", 16'(n / div[k]), 16'h0010);
      rd(8'h9d);
      chk("status", {14'h0, rv[1:0]}, 16'h0001);
      chk_res(1'b0);
      // Keep the reference as it is, so no unannounced switch to it
      wr(8'h9c, fmt | 8'h80);
      chk_res(1'b1);
      rd(8'ha0);
      chk("done_flag", rv, 16'h0001);
      chk("irq_masked", {15'h0, IRQ_O}, 16'h0000);
      wr(8'ha0, 8'h03);
      repeat (2) @(negedge MCLK_I);
      chk("irq", {15'h0, IRQ_O}, 16'h0001);
      wr(8'ha0, 8'h00);
      repeat (2) @(negedge MCLK_I);
      chk("irq_clear", {15'h0, IRQ_O}, 16'h0000);
      $display("test conversion %0d done", k);
    end
    // Abort in the bit phase, then the hold-off and resumed sampling
    wr(8'h9d, 8'h17);
    repeat (40) @(posedge MCLK_I);
    wr(8'h9d, 8'h15);
    repeat (10) @(negedge MCLK_I);
    chk("abort", {14'h0, BUSY_O, SAMPLE_O}, 16'h0000);
    repeat (30) @(negedge MCLK_I);
    chk("resume", {15'h0, SAMPLE_O}, 16'h0001);
    chk_res(1'b1);
    $display("test abort done");
    // Start held pending through sleep
    @(posedge MCLK_I);
    SLEEP_I <= 1'b1;
    wr(8'h9d, 8'h17);
    repeat (200) @(negedge MCLK_I);
    chk("sleep_hold", {14'h0, BUSY_O, SAMPLE_O}, 16'h0002);
    rd(8'ha0);
    chk("sleep_nodone", rv, 16'h0000);
    level = 12'($urandom);
    @(posedge MCLK_I);
    SLEEP_I <= 1'b0;
    wait_done();
    chk("wake_conv", 16'(n / 8), 16'h0010);
    chk_res(1'b1);
    $display("test sleep done");
    // Reset in mid-conversion
    wr(8'h9d, 8'h17);
    repeat (30) @(posedge MCLK_I);
    RST_B_I <= 1'b0;
    repeat (2) @(posedge MCLK_I);
    RST_B_I <= 1'b1;
    @(negedge MCLK_I);
    chk("reset_busy", {14'h0, BUSY_O, IRQ_O}, 16'h0000);
    rd(8'h9d);
    chk("reset_main", rv, 16'h0000);
    $display("test reset done");
    results();
  end
endmodule : sar_adc_sequencer_test
`default_nettype wire

// >>> sim/sas_adc_seq_props.sv
// Checker on the converter sequencer top-level ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module sas_adc_seq_props
(
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic SLEEP_I,
  input wire logic CMP_I,
  input wire logic [4:0] CH_SEL_O,
  input wire logic REF_INT_O,
  input wire logic REF_LVL_O,
  input wire logic SAMPLE_O,
  input wire logic [11:0] TRIAL_O,
  input wire logic BUSY_O,
  input wire logic IRQ_O
);
  logic [1:0] fw;
  logic [1:0] bd;
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RST_B_I);
  // Flag writes and busy of the last two cycles; the irq may lag by one
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
    begin
      fw <= 2'b00;
      bd <= 2'b00;
    end
    else
    begin
      fw <= {fw[0], WR_I && ADDR_I == 8'ha0};
      bd <= {bd[0], BUSY_O};
    end
  end
  property p_start;
    $rose(BUSY_O) |-> $past(WR_I) && $past(ADDR_I) == 8'h9d
      && $past(WDATA_I[1]) && $past(WDATA_I[0]);
  endproperty
  a_start: assert property (p_start) else $error("busy without start");
  property p_chan;
    $past(WR_I) && $past(ADDR_I) == 8'h9d
      |-> CH_SEL_O[3:0] == $past(WDATA_I[5:2]);
  endproperty
  a_chan: assert property (p_chan) else $error("channel low bits");
  property p_ref;
    $past(WR_I) && $past(ADDR_I) == 8'h9c |-> CH_SEL_O[4] == $past(WDATA_I[6])
      && REF_INT_O == $past(WDATA_I[2]) && REF_LVL_O == $past(WDATA_I[0]);
  endproperty
  a_ref: assert property (p_ref) else $error("format fields");
  property p_fmt_zero;
    $past(RD_I) && $past(ADDR_I) == 8'h9c |-> RDATA_O[5:3] == 3'h0
      && !RDATA_O[1];
  endproperty
  a_fmt_zero: assert property (p_fmt_zero) else $error("unused bits");
  property p_trial_idle;
    SAMPLE_O && $past(SAMPLE_O) && !BUSY_O |-> $stable(TRIAL_O);
  endproperty
  a_trial_idle: assert property (p_trial_idle) else $error("trial moved");
  property p_sleep;
    SLEEP_I [*3] |-> !SAMPLE_O && $stable(TRIAL_O);
  endproperty
  a_sleep: assert property (p_sleep) else $error("active in sleep");
  property p_irq_rise;
    $rose(IRQ_O) |-> |fw || (bd[0] && !BUSY_O) || (bd[1] && !bd[0]);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("stray irq");
  property p_irq_fall;
    $fell(IRQ_O) |-> |fw;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped");
  property p_reset;
    disable iff (1'b0) !RST_B_I |=> !BUSY_O && !IRQ_O && !SAMPLE_O
      && TRIAL_O == 12'h000 && CH_SEL_O == 5'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state");
  c_done: cover property ($fell(BUSY_O));
  c_irq: cover property ($rose(IRQ_O));
  c_sleep: cover property (SLEEP_I && BUSY_O);
endmodule : sas_adc_seq_props

bind sas_adc_seq sas_adc_seq_props u_props (.MCLK_I(MCLK_I),
  .RST_B_I(RST_B_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .SLEEP_I(SLEEP_I), .CMP_I(CMP_I),
  .CH_SEL_O(CH_SEL_O), .REF_INT_O(REF_INT_O), .REF_LVL_O(REF_LVL_O),
  .SAMPLE_O(SAMPLE_O), .TRIAL_O(TRIAL_O), .BUSY_O(BUSY_O), .IRQ_O(IRQ_O));
`default_nettype wire

// >>> sim/sas_afe_model.sv
// Stand-in for the shared sample-and-hold and comparator.
// Assumes the bench sets the input level; no real analog behaviour.
`timescale 1ns/100ps
`default_nettype none
module sas_afe_model
(
  input wire logic clk_i,
  input wire logic sample_i,
  input wire logic [11:0] trial_i,
  input wire logic [11:0] level_i,
  output logic cmp_o
);
  logic [11:0] held = 12'h000;
  // Tracks while sampling, holds through the bit decisions
  always @(posedge clk_i)
    if (sample_i)
      held <= level_i;
  // Unclocked, as the real comparator; the design synchronises it
  assign cmp_o = (held >= trial_i);
endmodule : sas_afe_model
`default_nettype wire

// >>> src/sas_adc_seq.sv
// Converter sequencer top: registers, start/abort control, alignment.
// Assumes a comparator and sample-and-hold outside, driven from here;
// the register port master never issues read and write together.
// Offsets, field positions and counts come from the constants header.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "sas_params.svh"

// Behaviour
// - Each conversion resolves 12 bits by successive approximation into result.
// - Five-bit channel code: 0 to 17 are inputs, 18 is 1.2V reference.
// - Clock select codes divide system clock by 8, 16, 32, 128.
// - A conversion lasts sixteen per-bit periods until status clears.
// - Done flag sets on every completion; only software clears it.
// - Interrupt request only when done flag and its enable are set.
// - Left alignment: bits 11..4 high, bits 3..0 in low upper nibble.
// - Right alignment: bits 11..10 high low bits, bits 9..2 low.
// - Conversion starts only with enable set and status written one.
// - Completion clears status, sets done flag, loads both result registers.
// - Clearing status early aborts; results keep last completed value.
// - After abort wait two periods, then sampling resumes by itself.
// - Reset clears all registers, disables converter, stops conversion.
// - No conversion runs while the device sleeps.
module sas_adc_seq
(
  input wire logic MCLK_I,
  input wire logic RST_B_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic SLEEP_I,
  input wire logic CMP_I,
  output logic [4:0] CH_SEL_O,
  output logic REF_INT_O,
  output logic REF_LVL_O,
  output logic SAMPLE_O,
  output logic [11:0] TRIAL_O,
  output logic BUSY_O,
  output logic IRQ_O
);

  sas_pkg::sas_main_t s;
  sas_pkg::sas_main_t next_s;
  // Handshakes with the divider and the trial register, all on MCLK_I
  logic tick;
  logic div_run;
  logic div_restart;
  logic sar_load;
  logic sar_decide;
  logic [11:0] trial;
  logic wr_fmt;
  logic wr_main;
  logic wr_flag;
  logic start_req;
  logic abort_req;

  // Address match, used by the write decode; the read mux compares ADDR_I in its own case
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // High result byte under the chosen alignment
  function automatic logic [7:0] res_high(input logic align,
                                          input logic [11:0] r);
    if (align)
      res_high = {6'h00, r[11:10]};
    else
      res_high = r[11:4];
  endfunction : res_high

  // Low result byte; right alignment drops the two lowest bits
  function automatic logic [7:0] res_low(input logic align,
                                         input logic [11:0] r);
    if (align)
      res_low = r[9:2];
    else
      res_low = {r[3:0], 4'h0};
  endfunction : res_low

  // Write decode; result offsets have no write path at all
  assign wr_fmt = WR_I && hit(ADDR_I, `SAS_OFF_FMT);
  assign wr_main = WR_I && hit(ADDR_I, `SAS_OFF_MAIN);
  assign wr_flag = WR_I && hit(ADDR_I, `SAS_OFF_FLAG);

  // Per-bit period divider; runs only while converting or aborting.
  // A clock select change in mid-conversion bends one period, so
  // software should change it only while idle.
  assign div_run = (s.state != sas_pkg::SAS_IDLE);
  assign div_restart = (s.state != next_s.state);

  sas_tad_div u_div
  (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .run_i(div_run),
    .restart_i(div_restart),
    .sel_i(s.clk_sel),
    .tick_o(tick)
  );

  // Bits are decided at the end of each period, so the comparator has
  // a whole period behind the two sync flops to settle
  // Trial register; loaded on entry to a conversion
  assign sar_load = (s.state == sas_pkg::SAS_IDLE)
                 && (next_s.state == sas_pkg::SAS_CONV);
  assign sar_decide = tick && (s.state == sas_pkg::SAS_CONV)
                   && (s.period >= `SAS_SAMPLE_TADS)
                   && (s.period <= `SAS_LAST_BIT_TAD);

  sas_sar_core u_sar
  (
    .clk_i(MCLK_I),
    .rst_b_i(RST_B_I),
    .load_i(sar_load),
    .decide_i(sar_decide),
    .cmp_i(s.cmp_sync),
    .trial_o(trial)
  );

  // Start needs the enable already on before this write
  // start condition
  assign start_req = wr_main && WDATA_I[`SAS_MAIN_GO]
                  && WDATA_I[`SAS_MAIN_EN] && s.enable;
  // Status written zero is an abort; status one with the enable bit
  // clear in the data is simply dropped
  assign abort_req = wr_main && !WDATA_I[`SAS_MAIN_GO];

  // Next-state logic: register writes first, then the sequencer,
  // so a hardware set of the done flag wins over a clearing write
  always_comb
  begin
    next_s = s;

    // Comparator is asynchronous to the clock; two flops first, as a
    // single flop could pass a metastable level into the trial bit
    next_s.cmp_meta = CMP_I;
    next_s.cmp_sync = s.cmp_meta;

    if (wr_fmt)
    begin
      next_s.align = WDATA_I[`SAS_FMT_ALIGN];
      next_s.ch_msb = WDATA_I[`SAS_FMT_CHMSB];
      next_s.ref_en = WDATA_I[`SAS_FMT_REFEN];
      next_s.ref_lvl = WDATA_I[`SAS_FMT_REFLVL];
    end

    if (wr_main)
    begin
      next_s.clk_sel = WDATA_I[`SAS_MAIN_CLKSEL +: 2];
      next_s.ch_lo = WDATA_I[`SAS_MAIN_CHLO +: 4];
      next_s.enable = WDATA_I[`SAS_MAIN_EN];
      if (start_req)
        next_s.go = 1'b1;
      else if (abort_req)
        next_s.go = 1'b0;
    end

    // Writing one to the done bit leaves it alone, so setting the
    // enable cannot wipe out a completion that has just landed
    // software clear of the flag
    if (wr_flag)
    begin
      next_s.irq_en = WDATA_I[`SAS_FLAG_IE];
      if (!WDATA_I[`SAS_FLAG_DONE])
        next_s.done_flag = 1'b0;
    end

    case (s.state)
      sas_pkg::SAS_IDLE:
      begin
        // A start written during sleep stays pending in the status bit
        // and begins on wake; one written in the hold-off runs after it
        // no start while asleep
        if (next_s.go && next_s.enable && !SLEEP_I)
        begin
          next_s.state = sas_pkg::SAS_CONV;
          next_s.period = 4'h0;
        end
      end

      sas_pkg::SAS_CONV:
      begin
        // Disable and sleep are handled like a status clear: the partial
        // trial is dropped and the hold-off still runs
        // abort keeps old result
        if (!next_s.go || !next_s.enable || SLEEP_I)
        begin
          next_s.state = sas_pkg::SAS_ABORT;
          next_s.go = 1'b0;
          next_s.period = 4'h0;
        end
        else if (tick)
        begin
          if (s.period == `SAS_LAST_CONV_TAD)
          begin
            // Result taken whole at the last edge, never bit by bit, so
            // a reader never sees a half-updated value
            // completion updates
            next_s.state = sas_pkg::SAS_IDLE;
            next_s.go = 1'b0;
            next_s.result = trial;
            next_s.done_flag = 1'b1;
            next_s.period = 4'h0;
          end
          else
            next_s.period = s.period + 4'h1;
        end
      end

      sas_pkg::SAS_ABORT:
      begin
        if (tick)
        begin
          if (s.period == `SAS_LAST_ABORT_TAD)
          begin
            next_s.state = sas_pkg::SAS_IDLE;
            next_s.period = 4'h0;
          end
          else
            next_s.period = s.period + 4'h1;
        end
      end

      default:
      begin
        next_s.state = sas_pkg::SAS_IDLE;
        next_s.period = 4'h0;
      end
    endcase

    // Idle tracks the input, so a start begins from a settled sample;
    // the hold-off keeps the switch open
    // sampling resumes after abort
    case (next_s.state)
      sas_pkg::SAS_IDLE:
        next_s.sample = next_s.enable && !SLEEP_I;
      sas_pkg::SAS_CONV:
        next_s.sample = (next_s.period < `SAS_SAMPLE_TADS);
      default:
        next_s.sample = 1'b0;
    endcase

    // Registered from the next flag value, so the request changes in the same clock as the flag
    // request gated by enable
    next_s.irq = next_s.done_flag && next_s.irq_en;

    // Read data stand in the cycle after the strobe only, and are zero
    // otherwise, so a late look by the master never sees stale data
    next_s.rdata = 8'h00;
    if (RD_I)
    begin
      case (ADDR_I)
        `SAS_OFF_FMT:
        begin
          next_s.rdata = {s.align, s.ch_msb, 3'h0, s.ref_en, 1'h0,
                          s.ref_lvl};
        end
        `SAS_OFF_MAIN:
        begin
          next_s.rdata = {s.clk_sel, s.ch_lo, s.go, s.enable};
        end
        // Alignment applied here, so a format change reformats the
        // last result without a new conversion
        `SAS_OFF_RESH:
        begin
          next_s.rdata = res_high(s.align, s.result);
        end
        `SAS_OFF_RESL:
        begin
          next_s.rdata = res_low(s.align, s.result);
        end
        `SAS_OFF_FLAG:
        begin
          next_s.rdata = {6'h00, s.irq_en, s.done_flag};
        end
        // Offsets outside the map read as zero
        default:
        begin
          next_s.rdata = 8'h00;
        end
      endcase
    end
  end

  // Reset is synchronous: hold it low across at least one rising edge
  // State register; reset turns the converter off mid-conversion
  // everything to reset state
  always_ff @(posedge MCLK_I)
  begin
    if (!RST_B_I)
      s <= '0;
    else
      s <= next_s;
  end

  // Channel code goes straight to the input multiplexer; reserved
  // codes above the reference are passed on and select nothing
  // channel routing
  assign CH_SEL_O = {s.ch_msb, s.ch_lo};

  // The regulator's settling time is left to software, no hardware wait
  // Reference control for the analog front end
  // reference source and level
  assign REF_INT_O = s.ref_en;
  assign REF_LVL_O = s.ref_lvl;

  // BUSY mirrors the status bit, so it is up through a pending start
  // Front-end controls, all from flops
  assign SAMPLE_O = s.sample;
  assign TRIAL_O = trial;
  assign BUSY_O = s.go;
  assign IRQ_O = s.irq;
  assign RDATA_O = s.rdata;

endmodule : sas_adc_seq
`default_nettype wire

// >>> src/sas_params.svh
// Constants for the successive-approximation converter sequencer.
// Assumes an 8-bit register port and a 125 MHz system clock.
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH

// Register offsets on the register port
`define SAS_OFF_FMT 8'h9c
`define SAS_OFF_MAIN 8'h9d
`define SAS_OFF_RESH 8'h9e
`define SAS_OFF_RESL 8'h9f
`define SAS_OFF_FLAG 8'ha0

// Reset values
`define SAS_FMT_RST 8'h00
`define SAS_MAIN_RST 8'h00
`define SAS_FLAG_RST 8'h00

// Field positions, format and reference register
`define SAS_FMT_ALIGN 7
`define SAS_FMT_CHMSB 6
`define SAS_FMT_REFEN 2
`define SAS_FMT_REFLVL 0

// Field positions, main control register
`define SAS_MAIN_CLKSEL 6
`define SAS_MAIN_CHLO 2
`define SAS_MAIN_GO 1
`define SAS_MAIN_EN 0

// Field positions, flag register
`define SAS_FLAG_IE 1
`define SAS_FLAG_DONE 0

// System clock ratios per conversion clock code
`define SAS_DIV_0 8'h08
`define SAS_DIV_1 8'h10
`define SAS_DIV_2 8'h20
`define SAS_DIV_3 8'h80

// Per-bit periods within one conversion and one abort
`define SAS_SAMPLE_TADS 4'h3
`define SAS_LAST_BIT_TAD 4'he
`define SAS_LAST_CONV_TAD 4'hf
`define SAS_LAST_ABORT_TAD 4'h1
`define SAS_MSB_IDX 4'hb
`define SAS_TRIAL_MSB 12'h800

`endif

// >>> src/sas_pkg.sv
// Types shared by the converter sequencer modules.
// Assumes the constants header is included where values are needed.
package sas_pkg;

  typedef enum logic [1:0] {SAS_IDLE, SAS_CONV, SAS_ABORT} sas_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } sas_div_t;

  typedef struct packed {
    logic [11:0] trial;
    logic [3:0] idx;
  } sas_sar_t;

  typedef struct packed {
    sas_state_t state;
    logic align;
    logic ch_msb;
    logic ref_en;
    logic ref_lvl;
    logic [1:0] clk_sel;
    logic [3:0] ch_lo;
    logic go;
    logic enable;
    logic done_flag;
    logic irq_en;
    logic irq;
    logic sample;
    logic [11:0] result;
    logic [3:0] period;
    logic [7:0] rdata;
    logic cmp_meta;
    logic cmp_sync;
  } sas_main_t;

endpackage : sas_pkg

// >>> src/sas_sar_core.sv
// Successive-approximation register: trial value and bit pointer.
// Assumes the comparator level is already synchronised.
`timescale 1ns/100ps
`default_nettype none
`include "sas_params.svh"

module sas_sar_core
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic load_i,
  input wire logic decide_i,
  input wire logic cmp_i,
  output logic [11:0] trial_o
);

  sas_pkg::sas_sar_t s;
  sas_pkg::sas_sar_t next_s;
  logic [11:0] cur_bit;
  logic [11:0] low_bit;

  // Masks for the bit under test and the one below it
  assign cur_bit = 12'h001 << s.idx;
  assign low_bit = cur_bit >> 1;

  // Comparator high keeps the trial bit, low drops it
  always_comb
  begin
    next_s = s;
    if (load_i)
    begin
      next_s.trial = `SAS_TRIAL_MSB;
      next_s.idx = `SAS_MSB_IDX;
    end
    else if (decide_i)
    begin
      next_s.trial = cmp_i ? s.trial : (s.trial & ~cur_bit);
      next_s.trial = next_s.trial | low_bit;
      if (s.idx != 4'h0)
        next_s.idx = s.idx - 4'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign trial_o = s.trial;

endmodule : sas_sar_core
`default_nettype wire

// >>> src/sas_tad_div.sv
// Per-bit conversion period divider: one-cycle tick every N clocks.
// Assumes run and restart come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "sas_params.svh"

module sas_tad_div
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic restart_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);

  sas_pkg::sas_div_t s;
  sas_pkg::sas_div_t next_s;
  logic [7:0] last;

  // Ratio lookup, last count is one below the ratio
  always_comb
  begin
    case (sel_i)
      2'h0: last = `SAS_DIV_0 - 8'h01;
      2'h1: last = `SAS_DIV_1 - 8'h01;
      2'h2: last = `SAS_DIV_2 - 8'h01;
      default: last = `SAS_DIV_3 - 8'h01;
    endcase
  end

  // Restart keeps the first period after it a full one
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run_i || restart_i)
      next_s.cnt = 8'h00;
    // Greater-or-equal, so a shorter ratio chosen mid-count cannot
    // run the counter round through all 256 values
    else if (s.cnt >= last)
    begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + 8'h01;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick_o = s.tick;

endmodule : sas_tad_div
`default_nettype wire
